// File: core/rhp_pkg.sv
`default_nettype none
package rhp_pkg;
	// Number of downstream ports and register command codes
	localparam int NP = 2;
	localparam logic [7:0] CMD_RD [NP] = '{8'h15, 8'h16};
	localparam logic [7:0] CMD_WR [NP] = '{8'h95, 8'h96};

	// Status bit positions in the lower half word
	localparam int B_CONN = 0;
	localparam int B_EN = 1;
	localparam int B_SUSP = 2;
	localparam int B_OC = 3;
	localparam int B_RST = 4;
	localparam int B_PWR = 8;
	localparam int B_LS = 9;

	// Write-one command bits in the lower half word
	localparam int W_CLR_EN = 0;
	localparam int W_SET_EN = 1;
	localparam int W_SET_SUSP = 2;
	localparam int W_CLR_SUSP = 3;
	localparam int W_SET_RST = 4;
	localparam int W_SET_PWR = 8;
	localparam int W_CLR_PWR = 9;

	// Change flags: upper half word, index within the five-bit field
	localparam int CHG_LSB = 16;
	localparam int CHG_W = 5;
	localparam int C_CONN = 0;
	localparam int C_EN = 1;
	localparam int C_SUSP = 2;
	localparam int C_OC = 3;
	localparam int C_RST = 4;

	// Values after reset
	localparam logic [CHG_W-1:0] CHG_RST = 5'h00;
	localparam logic [NP-1:0] STAT_RST = 2'h0;
	localparam logic [31:0] RD_RST = 32'h0000_0000;

	// Timing
	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned RESET_MS = 10;
	localparam int unsigned RESUME_MS = 20;
	localparam int unsigned RESYNC_MS = 3;
	localparam int unsigned EOP_NS = 1333;
	localparam int unsigned RESET_CYC = RESET_MS * CLK_KHZ;
	localparam int unsigned RESUME_CYC = RESUME_MS * CLK_KHZ;
	localparam int unsigned RESYNC_CYC = RESYNC_MS * CLK_KHZ;
	localparam int unsigned EOP_CYC = (EOP_NS * (CLK_KHZ / 1000) + 999) / 1000;
	localparam int TMR_W = 20;

	typedef enum logic [2:0] {PH_IDLE, PH_RESET, PH_RESUME, PH_EOP, PH_RESYNC} rhp_phase_t;
endpackage
`default_nettype wire

// File: core/rhp_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rhp_cycle_timer #(
	parameter int W = 20
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic load_in,
	input wire logic [W-1:0] count_in,
	output logic done_out
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic done_r;
	logic done_nxt;

	// Done pulses in the cycle that the loaded count reaches zero
	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		if (load_in) begin
			cnt_nxt = count_in;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
			done_nxt = (cnt_r == W'(1));
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done_out = done_r;
endmodule
`default_nettype wire

// File: core/rhp_port_regs.sv
// Function
// R1 - One port register per downstream port
// R2 - Low half status, high half change flags
// R3 - Read codes 15h and 16h return registers
// R4 - Write codes 95h and 96h update registers
// R5 - Software writes zero to reserved bits
// R6 - Reset-done flag set after 10 ms reset
// R7 - Change flags cleared by writing one
// R8 - Overcurrent flag set when indicator changes
// R9 - Overcurrent flag meaningless in global mode
// R10 - Suspend flag set after full resume sequence
// R11 - Reset-done set clears suspend flag
// R12 - Enable flag set on hardware disable
// R13 - Software enable changes leave flag alone
// R14 - Flags and status bits reset to zero
// R15 - Connect flag on attach, detach, bad request
// R16 - Hardware set beats software clear
`timescale 1ns/1ps
`default_nettype none
module rhp_port_regs import rhp_pkg::*; #(
	parameter int unsigned RESET_CYCLES = RESET_CYC,
	parameter int unsigned RESUME_CYCLES = RESUME_CYC,
	parameter int unsigned RESYNC_CYCLES = RESYNC_CYC
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [31:0] cmd_wdata_in,
	input wire logic per_port_oc_in,
	input wire logic [NP-1:0] connect_in,
	input wire logic [NP-1:0] low_speed_in,
	input wire logic [NP-1:0] overcurrent_in,
	input wire logic [NP-1:0] remote_resume_in,
	input wire logic [NP-1:0] hw_disable_in,
	output logic [31:0] rd_data_out,
	output logic rd_valid_out,
	output logic [NP-1:0] port_power_out,
	output logic [NP-1:0] port_enabled_out,
	output logic [NP-1:0] port_suspended_out,
	output logic [NP-1:0] port_reset_out,
	output logic [NP-1:0] port_resume_out,
	output logic [NP-1:0] port_eop_out
);
	logic [NP-1:0] conn_r, conn_nxt;
	logic [NP-1:0] en_r, en_nxt;
	logic [NP-1:0] susp_r, susp_nxt;
	logic [NP-1:0] oc_r, oc_nxt;
	logic [NP-1:0] rst_r, rst_nxt;
	logic [NP-1:0] pwr_r, pwr_nxt;
	logic [NP-1:0] ls_r, ls_nxt;
	logic [NP-1:0] resume_r, resume_nxt;
	logic [NP-1:0] eop_r, eop_nxt;
	logic [CHG_W-1:0] chg_r [NP];
	logic [CHG_W-1:0] chg_nxt [NP];
	rhp_phase_t phase_r [NP];
	rhp_phase_t phase_nxt [NP];
	logic [31:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [NP-1:0] tload;
	logic [TMR_W-1:0] tcnt [NP];
	logic [NP-1:0] tdone;

	// One sequencing timer per port
	for (genvar g = 0; g < NP; g++) begin : g_tmr // see R1
		rhp_cycle_timer #(
			.W(TMR_W)
		) u_tmr (
			.clock_in(clock_in),
			.sys_rst_in(sys_rst_in),
			.load_in(tload[g]),
			.count_in(tcnt[g]),
			.done_out(tdone[g])
		);
	end

	always_comb begin
		logic wr;
		logic [CHG_W-1:0] set;
		logic [CHG_W-1:0] clr;
		wr = 1'b0;
		set = '0;
		clr = '0;
		conn_nxt = conn_r;
		en_nxt = en_r;
		susp_nxt = susp_r;
		oc_nxt = oc_r;
		rst_nxt = rst_r;
		pwr_nxt = pwr_r;
		ls_nxt = ls_r;
		resume_nxt = resume_r;
		eop_nxt = eop_r;
		tload = '0;
		for (int p = 0; p < NP; p++) begin
			chg_nxt[p] = chg_r[p];
			phase_nxt[p] = phase_r[p];
			tcnt[p] = '0;
		end
		rd_valid_nxt = 1'b0;
		rd_data_nxt = rd_data_r;

		for (int p = 0; p < NP; p++) begin
			wr = cmd_valid_in && (cmd_code_in == CMD_WR[p]); // see R4
			set = '0;
			clr = wr ? cmd_wdata_in[CHG_LSB +: CHG_W] : '0; // see R7

			// Attach and detach
			conn_nxt[p] = connect_in[p];
			ls_nxt[p] = connect_in[p] & low_speed_in[p];
			if (connect_in[p] != conn_r[p]) begin
				set[C_CONN] = 1'b1; // see R15
			end

			// Software commands, one-written bits only
			if (wr) begin
				if (cmd_wdata_in[W_CLR_EN]) begin
					en_nxt[p] = 1'b0; // see R13
				end
				if (cmd_wdata_in[W_SET_EN]) begin
					if (conn_r[p]) begin
						en_nxt[p] = 1'b1; // see R13
					end else begin
						set[C_CONN] = 1'b1; // see R15
					end
				end
				if (cmd_wdata_in[W_SET_SUSP]) begin
					if (!conn_r[p]) begin
						set[C_CONN] = 1'b1; // see R15
					end else if (en_r[p] && phase_r[p] == PH_IDLE) begin
						susp_nxt[p] = 1'b1;
					end
				end
				if (cmd_wdata_in[W_CLR_SUSP] && susp_r[p] && phase_r[p] == PH_IDLE) begin
					phase_nxt[p] = PH_RESUME; // see R10
					tload[p] = 1'b1;
					tcnt[p] = TMR_W'(RESUME_CYCLES);
				end
				if (cmd_wdata_in[W_SET_RST]) begin
					if (!conn_r[p]) begin
						set[C_CONN] = 1'b1; // see R15
					end else if (phase_r[p] == PH_IDLE) begin
						rst_nxt[p] = 1'b1;
						phase_nxt[p] = PH_RESET;
						tload[p] = 1'b1;
						tcnt[p] = TMR_W'(RESET_CYCLES);
					end
				end
				if (cmd_wdata_in[W_SET_PWR]) begin
					pwr_nxt[p] = 1'b1;
				end
				if (cmd_wdata_in[W_CLR_PWR]) begin
					pwr_nxt[p] = 1'b0;
					en_nxt[p] = 1'b0;
				end
			end

			// Device-initiated resume of a suspended port
			if (remote_resume_in[p] && susp_r[p] && phase_r[p] == PH_IDLE && !tload[p]) begin
				phase_nxt[p] = PH_RESUME;
				tload[p] = 1'b1;
				tcnt[p] = TMR_W'(RESUME_CYCLES);
			end

			// Reset and resume sequencing
			case (phase_r[p])
				PH_IDLE: begin
				end
				PH_RESET: begin
					if (tdone[p]) begin
						rst_nxt[p] = 1'b0;
						en_nxt[p] = conn_r[p];
						set[C_RST] = 1'b1; // see R6
						phase_nxt[p] = PH_IDLE;
					end
				end
				PH_RESUME: begin
					if (tdone[p]) begin
						phase_nxt[p] = PH_EOP;
						tload[p] = 1'b1;
						tcnt[p] = TMR_W'(EOP_CYC);
					end
				end
				PH_EOP: begin
					if (tdone[p]) begin
						phase_nxt[p] = PH_RESYNC;
						tload[p] = 1'b1;
						tcnt[p] = TMR_W'(RESYNC_CYCLES);
					end
				end
				PH_RESYNC: begin
					if (tdone[p]) begin
						susp_nxt[p] = 1'b0;
						set[C_SUSP] = 1'b1; // see R10
						phase_nxt[p] = PH_IDLE;
					end
				end
				default: begin
					phase_nxt[p] = PH_IDLE;
				end
			endcase

			// Overcurrent only tracked when reported per port
			oc_nxt[p] = per_port_oc_in & overcurrent_in[p]; // see R9
			if (per_port_oc_in && oc_nxt[p] != oc_r[p]) begin
				set[C_OC] = 1'b1; // see R8
			end

			// Hardware disable only acts on an enabled port; a same-cycle software enable of a disabled port still takes effect
			if (en_r[p] && (hw_disable_in[p] || !connect_in[p] || oc_nxt[p])) begin
				en_nxt[p] = 1'b0;
				set[C_EN] = 1'b1; // see R12
			end
			if (!connect_in[p]) begin
				susp_nxt[p] = 1'b0;
			end

			// Reset completion drops a pending resume indication
			if (set[C_RST]) begin
				clr[C_SUSP] = 1'b1; // see R11
				set[C_SUSP] = 1'b0;
			end
			chg_nxt[p] = (chg_r[p] & ~clr) | set; // see R16

			resume_nxt[p] = (phase_nxt[p] == PH_RESUME);
			eop_nxt[p] = (phase_nxt[p] == PH_EOP);

			if (cmd_valid_in && cmd_code_in == CMD_RD[p]) begin // see R3
				rd_valid_nxt = 1'b1;
				rd_data_nxt = '0;
				rd_data_nxt[CHG_LSB +: CHG_W] = chg_r[p]; // see R2
				rd_data_nxt[B_LS] = ls_r[p];
				rd_data_nxt[B_PWR] = pwr_r[p];
				rd_data_nxt[B_RST] = rst_r[p];
				rd_data_nxt[B_OC] = oc_r[p];
				rd_data_nxt[B_SUSP] = susp_r[p];
				rd_data_nxt[B_EN] = en_r[p];
				rd_data_nxt[B_CONN] = conn_r[p];
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			conn_r <= STAT_RST; // see R14
			en_r <= STAT_RST;
			susp_r <= STAT_RST;
			oc_r <= STAT_RST;
			rst_r <= STAT_RST;
			pwr_r <= STAT_RST;
			ls_r <= STAT_RST;
			resume_r <= STAT_RST;
			eop_r <= STAT_RST;
			for (int p = 0; p < NP; p++) begin
				chg_r[p] <= CHG_RST;
				phase_r[p] <= PH_IDLE;
			end
			rd_data_r <= RD_RST;
			rd_valid_r <= 1'b0;
		end else begin
			conn_r <= conn_nxt;
			en_r <= en_nxt;
			susp_r <= susp_nxt;
			oc_r <= oc_nxt;
			rst_r <= rst_nxt;
			pwr_r <= pwr_nxt;
			ls_r <= ls_nxt;
			resume_r <= resume_nxt;
			eop_r <= eop_nxt;
			for (int p = 0; p < NP; p++) begin
				chg_r[p] <= chg_nxt[p];
				phase_r[p] <= phase_nxt[p];
			end
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	assign rd_data_out = rd_data_r;
	assign rd_valid_out = rd_valid_r;
	assign port_power_out = pwr_r;
	assign port_enabled_out = en_r;
	assign port_suspended_out = susp_r;
	assign port_reset_out = rst_r;
	assign port_resume_out = resume_r;
	assign port_eop_out = eop_r;
endmodule
`default_nettype wire

// File: dv/rhp_usb_dev.sv
`timescale 1ns/1ps
`default_nettype none
module rhp_usb_dev import rhp_pkg::*; (
	input wire logic clock_in,
	input wire logic [NP-1:0] plug_in,
	input wire logic [NP-1:0] ls_in,
	input wire logic [NP-1:0] oc_in,
	input wire logic [NP-1:0] wake_in,
	output logic [NP-1:0] connect_out,
	output logic [NP-1:0] low_speed_out,
	output logic [NP-1:0] overcurrent_out,
	output logic [NP-1:0] remote_resume_out
);
	initial begin
		connect_out = '0;
		low_speed_out = '0;
		overcurrent_out = '0;
		remote_resume_out = '0;
	end
	// Device lines update just after the sampling edge, clear of bench drive races
	always @(posedge clock_in) begin
		connect_out <= plug_in;
		// Speed is only signalled by an attached device
		low_speed_out <= plug_in & ls_in;
		overcurrent_out <= oc_in;
		remote_resume_out <= plug_in & wake_in;
	end
endmodule
`default_nettype wire

// File: dv/rhp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rhp_port_monitor import rhp_pkg::*; (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [31:0] cmd_wdata_in,
	input wire logic [NP-1:0] connect_in,
	input wire logic [NP-1:0] hw_disable_in,
	input wire logic [31:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic [NP-1:0] port_power_out,
	input wire logic [NP-1:0] port_enabled_out,
	input wire logic [NP-1:0] port_reset_out,
	input wire logic [NP-1:0] port_resume_out,
	input wire logic [NP-1:0] port_eop_out
);
	wire is_rd = cmd_valid_in && (cmd_code_in == CMD_RD[0] || cmd_code_in == CMD_RD[1]);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	a_read_answer: assert property (is_rd |=> rd_valid_out)
		else $error("read not answered");
	a_no_answer: assert property (!is_rd |=> !rd_valid_out)
		else $error("answer without read");
	a_reserved_zero: assert property (rd_valid_out |-> (rd_data_out & 32'hFFE0_FCE0) == 32'h0000_0000)
		else $error("reserved bit set");
	a_reset_clear: assert property ($fell(sys_rst_in) |-> !rd_valid_out && port_power_out == 2'h0
		&& port_enabled_out == 2'h0 && port_reset_out == 2'h0)
		else $error("state not cleared");
	a_reset_done: assert property ($fell(port_reset_out[0]) |-> port_enabled_out[0])
		else $error("reset end without enable");
	a_resume_order: assert property ($fell(port_resume_out[0]) |-> port_eop_out[0])
		else $error("resume not followed by eop");
	a_bad_request: assert property (cmd_valid_in && cmd_code_in == CMD_WR[1]
		&& cmd_wdata_in[W_SET_RST] && !connect_in[1] && !$past(connect_in[1]) && !port_reset_out[1]
		|=> !port_reset_out[1])
		else $error("reset on empty port");
	a_power_off: assert property (cmd_valid_in && cmd_code_in == CMD_WR[1]
		&& cmd_wdata_in[W_CLR_PWR] && !cmd_wdata_in[W_SET_PWR]
		|=> !port_power_out[1] && !port_enabled_out[1])
		else $error("power not cleared");
	a_hw_disable: assert property (hw_disable_in[0] && port_enabled_out[0]
		|-> ##[1:2] !port_enabled_out[0])
		else $error("hardware disable ignored");
endmodule
bind rhp_port_regs rhp_port_monitor mon (
	.clock_in(clock_in),
	.sys_rst_in(sys_rst_in),
	.cmd_valid_in(cmd_valid_in),
	.cmd_code_in(cmd_code_in),
	.cmd_wdata_in(cmd_wdata_in),
	.connect_in(connect_in),
	.hw_disable_in(hw_disable_in),
	.rd_data_out(rd_data_out),
	.rd_valid_out(rd_valid_out),
	.port_power_out(port_power_out),
	.port_enabled_out(port_enabled_out),
	.port_reset_out(port_reset_out),
	.port_resume_out(port_resume_out),
	.port_eop_out(port_eop_out)
);
`default_nettype wire

// File: dv/rhp_port_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rhp_port_regs_bench import rhp_pkg::*; ;
	logic clk = 0, rst = 1, vld = 0, pp = 0;
	logic [7:0] code = 0;
	logic [31:0] wd = 0, rdd;
	logic [1:0] plug = 0, ls = 0, oc = 0, wake = 0, hwd = 0;
	logic [1:0] con, lso, oco, rres, pw, en, su, pr, rs, eo;
	logic rdv;
	int failures = 0, tests_run = 0;
	int n_res = 0, n_eop = 0, n_rst = 0;
	localparam int RST_T = 20;
	localparam int RES_T = 30;
	logic [79:0] rows [8] = '{
		{8'h95, 32'h0001_0000, 8'h15, 32'h0000_0001},
		{8'h96, 32'h0001_0000, 8'h16, 32'h0000_0201},
		{8'h95, 32'h0000_0100, 8'h15, 32'h0000_0101},
		{8'h95, 32'h0000_0002, 8'h15, 32'h0000_0103},
		{8'h95, 32'h0000_0001, 8'h15, 32'h0000_0101},
		{8'h95, 32'h0000_0000, 8'h15, 32'h0000_0101},
		{8'h97, 32'h0000_0100, 8'h16, 32'h0000_0201},
		{8'h96, 32'h0000_0200, 8'h16, 32'h0000_0201}};
	always #12.5 clk = ~clk;
	rhp_usb_dev dev (.clock_in(clk), .plug_in(plug), .ls_in(ls), .oc_in(oc), .wake_in(wake),
		.connect_out(con), .low_speed_out(lso), .overcurrent_out(oco),
		.remote_resume_out(rres));
	rhp_port_regs #(.RESET_CYCLES(RST_T), .RESUME_CYCLES(RES_T), .RESYNC_CYCLES(10)) dut (
		.clock_in(clk), .sys_rst_in(rst), .cmd_valid_in(vld), .cmd_code_in(code),
		.cmd_wdata_in(wd), .per_port_oc_in(pp), .connect_in(con), .low_speed_in(lso),
		.overcurrent_in(oco), .remote_resume_in(rres), .hw_disable_in(hwd),
		.rd_data_out(rdd), .rd_valid_out(rdv), .port_power_out(pw), .port_enabled_out(en),
		.port_suspended_out(su), .port_reset_out(pr), .port_resume_out(rs), .port_eop_out(eo));
	task cmd(input logic [7:0] c, input logic [31:0] d);
		@(negedge clk);
		vld = 1;
		code = c;
		wd = d & 32'h001F_031F;
		@(negedge clk);
		vld = 0;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	// Answer arrives one edge after the command is taken
	task rd(input logic [7:0] c, input logic [31:0] e);
		cmd(c, 32'h0);
		chk("rd_valid", 32'h1, {31'h0, rdv});
		chk("rd_data", e, rdd);
	endtask
	task report_and_stop();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#50000;
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(negedge clk);
		rst = 0;
		rd(8'h15, 32'h0);
		cmd(8'h96, 32'h0000_0010);
		rd(8'h16, 32'h0001_0000);
		plug = 2'b11;
		ls = 2'b10;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			cmd(rows[i][79:72], rows[i][71:40]);
			rd(rows[i][39:32], rows[i][31:0]);
		end
		cmd(8'h95, 32'h0000_0002);
		cmd(8'h95, 32'h0000_0004);
		rd(8'h15, 32'h0000_0107);
		chk("levels", 32'h0000_0054, {24'h0, pw, en, su, pr});
		cmd(8'h95, 32'h0000_0008);
		for (int i = 0; i < 200 && su[0] === 1'b1; i++) begin
			n_res += rs[0];
			n_eop += eo[0];
			@(negedge clk);
		end
		chk("resume_cycles", RES_T + 1, n_res);
		chk("eop_cycles", EOP_CYC + 1, n_eop);
		rd(8'h15, 32'h0004_0103);
		cmd(8'h95, 32'h0000_0010);
		chk("levels", 32'h0000_0051, {24'h0, pw, en, su, pr});
		for (int i = 0; i < 100 && pr[0] === 1'b1; i++) begin
			n_rst += pr[0];
			@(negedge clk);
		end
		chk("reset_cycles", RST_T + 1, n_rst);
		rd(8'h15, 32'h0010_0103);
		cmd(8'h95, 32'h0014_0000);
		rd(8'h15, 32'h0000_0103);
		// Device-driven resume of a suspended port
		cmd(8'h95, 32'h0000_0004);
		wake = 2'b01;
		for (int i = 0; i < 200 && su[0] === 1'b1; i++) @(negedge clk);
		wake = 2'b00;
		rd(8'h15, 32'h0004_0103);
		cmd(8'h95, 32'h0004_0000);
		@(negedge clk);
		hwd = 2'b01;
		vld = 1;
		code = 8'h95;
		wd = 32'h0002_0000;
		@(negedge clk);
		hwd = 2'b00;
		vld = 0;
		rd(8'h15, 32'h0002_0101);
		chk("levels", 32'h0000_0040, {24'h0, pw, en, su, pr});
		oc = 2'b10;
		repeat (3) @(negedge clk);
		rd(8'h16, 32'h0000_0201);
		oc = 2'b00;
		pp = 1;
		repeat (3) @(negedge clk);
		oc = 2'b10;
		repeat (3) @(negedge clk);
		rd(8'h16, 32'h0008_0209);
		// Reset in mid-run with a device still attached
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		chk("levels", 32'h0000_0000, {24'h0, pw, en, su, pr});
		rd(8'h16, 32'h0009_0209);
		report_and_stop();
	end
endmodule
`default_nettype wire
